// ### pkg/ppf_pkg.sv
// package: fuse layout, defaults, commands and timing for the parallel programming port
package ppf_pkg;
   localparam logic [7:0] EXT_DEFAULT = 8'hFF;
   localparam logic [7:0] HIGH_DEFAULT = 8'h99;
   localparam logic [7:0] LOW_DEFAULT = 8'h62;
   localparam logic [7:0] LOCK_DEFAULT = 8'hFF;
   localparam logic [7:0] EXT_UNUSED_MASK = 8'hF8;
   localparam int EXT_BROWNOUT_HI = 2;
   localparam int EXT_BROWNOUT_LO = 1;
   localparam int EXT_RESET_DISABLE = 0;
   localparam int HIGH_DEBUG = 7;
   localparam int HIGH_SCAN = 6;
   localparam int HIGH_SERIAL_PROG = 5;
   localparam int HIGH_WATCHDOG = 4;
   localparam int HIGH_KEEP_EEPROM = 3;
   localparam int HIGH_BOOT_SIZE_HI = 2;
   localparam int HIGH_BOOT_SIZE_LO = 1;
   localparam int HIGH_BOOT_VECTOR = 0;
   localparam int LOW_DIV_EIGHT = 7;
   localparam int LOW_CLOCK_PIN = 6;
   localparam int LOW_STARTUP_HI = 5;
   localparam int LOW_STARTUP_LO = 4;
   localparam int LOCK_LEVEL_BIT0 = 0;
   localparam logic [3:0] CLOCK_SOURCE_RC8 = 4'h2;
   localparam logic [1:0] STARTUP_LONGEST = 2'h2;
   localparam logic [3:0] ENTRY_PATTERN = 4'h0;
   localparam logic [1:0] ACT_ADDR = 2'h0;
   localparam logic [1:0] ACT_DATA = 2'h1;
   localparam logic [1:0] ACT_CMD = 2'h2;
   localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
   localparam logic [7:0] CMD_WRITE_FUSE = 8'h40;
   localparam logic [7:0] CMD_WRITE_LOCK = 8'h20;
   localparam logic [7:0] CMD_WRITE_FLASH = 8'h10;
   localparam logic [7:0] CMD_WRITE_EEPROM = 8'h11;
   localparam logic [7:0] CMD_READ_SIG = 8'h08;
   localparam logic [7:0] CMD_READ_FUSE = 8'h04;
   localparam logic [7:0] CMD_READ_FLASH = 8'h02;
   localparam logic [7:0] CMD_READ_EEPROM = 8'h03;
   localparam int FLASH_PAGE_WORD_BITS = 6;
   localparam int EEPROM_PAGE_BYTE_BITS = 2;
   localparam int PAGE_INDEX_BITS = 8;
   localparam int CLK_PERIOD_NS = 8;
   localparam int MIN_PULSE_NS = 250;
   localparam int MIN_PULSE_CYC = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BUSY_NS = 1000;
   localparam int BUSY_CYC = BUSY_NS / CLK_PERIOD_NS;
   localparam logic [7:0] SIG_BYTE0 = 8'hA5;
   localparam logic [7:0] SIG_BYTE1 = 8'h5A;
   localparam logic [7:0] SIG_BYTE2 = 8'h3C;
   localparam logic [7:0] TRIM_DEFAULT = 8'h80;
endpackage

// ### pkg/ppf_strobe_if.sv
// interface: edge events of the programming strobes (rising for load and page latch, falling for the write strobe)
`timescale 1ns/1ps
`default_nettype none
interface ppf_strobe_if;
   logic load_rise;
   logic prog_fall;
   logic page_rise;
   modport det (output load_rise, output prog_fall, output page_rise);
   modport core (input load_rise, input prog_fall, input page_rise);
endinterface
`default_nettype wire

// ### core/ppf_edge_detect.sv
// strobe edge detector for the three programming strobes
`timescale 1ns/1ps
`default_nettype none
module ppf_edge_detect (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic load_strobe,
   input wire logic program_strobe_n,
   input wire logic page_latch_strobe,
   ppf_strobe_if.det ev
);
   logic load_q;
   logic prog_q;
   logic page_q;
   // previous levels; reset to idle so no false edge follows reset
   always_ff @(posedge core_clk) begin
      if (reset) begin
         load_q <= 1'b0;
         prog_q <= 1'b1;
         page_q <= 1'b0;
      end else begin
         load_q <= load_strobe;
         prog_q <= program_strobe_n;
         page_q <= page_latch_strobe;
      end
   end
   assign ev.load_rise = load_strobe & ~load_q;
   assign ev.prog_fall = ~program_strobe_n & prog_q;
   assign ev.page_rise = page_latch_strobe & ~page_q;
endmodule
`default_nettype wire

// ### core/ppf_fuse_port.sv
// fuse store, signature space and command front end of the parallel programming port
// Notes on behaviour
// R1: fuse bits read 0 when programmed and 1 when unprogrammed.
// R2: extended byte: bits 7..3 read 1, brownout 2..1, reset disable 0.
// R3: high byte layout with defaults 1,0,0,1,1,00,1.
// R4: low byte layout with defaults 0,1,1,0,0010.
// R5: default clock source is 8 MHz RC with longest start-up.
// R6: serial mode cannot touch the serial programming enable fuse.
// R7: chip erase never changes fuse values.
// R8: fuse writes blocked once lock level bit0 is programmed.
// R9: working fuse copies taken at mode entry, updated at exit.
// R10: keep-eeprom fuse acts at once when programmed.
// R11: working fuse copies also taken at normal power-up.
// R12: three identity bytes at signature 0..2, readable even when locked.
// R13: trim byte in high byte of signature 0, copied on each reset.
// R14: programmer holds each control pulse at least 250 ns.
// R15: ready_busy_n low while busy, high when ready.
// R16: programmer picks bytes with byte_select_hi_lo and byte_select_ext.
// R17: data bus driven only while output_enable_n is low.
// R18: entry pattern is four select pins all low.
// R19: load strobe acts on action select: address, data, command, idle.
// R20: write and output-enable strobes execute the last loaded command.
// R21: nine command bytes are decoded; the port decodes seven, leaving out read flash and read eeprom.
// R22: flash address splits into word in page and page index.
// R23: eeprom address splits into byte in page and page index.
// R24: command and address survive programming operations.
// R25: programmer waits after entry before its first command.
// R26: write strobe starts a write and holds busy until done.
// R27: strobes ignored while busy.
`timescale 1ns/1ps
`default_nettype none
module ppf_fuse_port #(
   parameter int BUSY_CYCLES = ppf_pkg::BUSY_CYC,
   parameter logic [7:0] SIG0 = ppf_pkg::SIG_BYTE0, // arbitrary value
   parameter logic [7:0] SIG1 = ppf_pkg::SIG_BYTE1, // arbitrary value
   parameter logic [7:0] SIG2 = ppf_pkg::SIG_BYTE2, // arbitrary value
   parameter logic [7:0] TRIM = ppf_pkg::TRIM_DEFAULT
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic prog_mode,
   input wire logic serial_mode,
   input wire logic load_strobe,
   input wire logic program_strobe_n,
   input wire logic output_enable_n,
   input wire logic page_latch_strobe,
   input wire logic pulse_action_sel1,
   input wire logic pulse_action_sel0,
   input wire logic byte_select_hi_lo,
   input wire logic byte_select_ext,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe,
   output logic ready_busy_n,
   output logic [7:0] fuse_low,
   output logic [7:0] fuse_high,
   output logic [7:0] fuse_ext,
   output logic keep_eeprom_on_erase,
   output logic rc_trim_register,
   output logic [7:0] rc_trim,
   output logic [7:0] lock_bits,
   output logic [7:0] addr_low,
   output logic [7:0] addr_high,
   output logic [7:0] command,
   output logic [7:0] page_word,
   output logic erase_pulse
);
   ppf_strobe_if ev();
   ppf_edge_detect u_edge (
      .core_clk(core_clk),
      .reset(reset),
      .load_strobe(load_strobe),
      .program_strobe_n(program_strobe_n),
      .page_latch_strobe(page_latch_strobe),
      .ev(ev)
   );

   typedef enum logic [1:0] {PPF_IDLE, PPF_BUSY} ppf_state_t;
   ppf_state_t state;
   logic [15:0] busy_cnt;
   logic [7:0] nv_low;
   logic [7:0] nv_high;
   logic [7:0] nv_ext;
   logic [7:0] data_low;
   logic [7:0] data_high;
   logic mode_q;
   logic init_done;
   logic [1:0] act;
   logic accept;
   logic start_write;
   logic fuse_wr_ok;
   logic [7:0] next_data_out;

   assign act = {pulse_action_sel1, pulse_action_sel0};
   // strobes count only when the port is ready
   assign accept = prog_mode & (state == PPF_IDLE); // R27
   assign start_write = accept & ev.prog_fall &
      (command == ppf_pkg::CMD_CHIP_ERASE || command == ppf_pkg::CMD_WRITE_FUSE ||
       command == ppf_pkg::CMD_WRITE_LOCK || command == ppf_pkg::CMD_WRITE_FLASH ||
       command == ppf_pkg::CMD_WRITE_EEPROM); // R20 R21 R26
   // lock level bit0 low means fuses are frozen
   assign fuse_wr_ok = lock_bits[ppf_pkg::LOCK_LEVEL_BIT0]; // R8

   // load strobe decode; registers are kept across operations
   always_ff @(posedge core_clk) begin
      if (reset) begin
         addr_low <= 8'h00;
         addr_high <= 8'h00;
         data_low <= 8'h00;
         data_high <= 8'h00;
         command <= 8'h00;
      end else if (accept && ev.load_rise) begin // R19 R24
         case (act)
            ppf_pkg::ACT_ADDR: begin
               if (byte_select_hi_lo) begin
                  addr_high <= data_in;
               end else begin
                  addr_low <= data_in;
               end
            end
            ppf_pkg::ACT_DATA: begin
               if (byte_select_hi_lo) begin
                  data_high <= data_in;
               end else begin
                  data_low <= data_in;
               end
            end
            ppf_pkg::ACT_CMD: command <= data_in;
            default: ;
         endcase
      end
   end

   // page latch captures the flash word offset, or the eeprom byte offset, in the page buffer
   always_ff @(posedge core_clk) begin
      if (reset) begin
         page_word <= 8'h00;
      end else if (accept && ev.page_rise) begin
         if (command == ppf_pkg::CMD_WRITE_EEPROM) begin
            page_word <= 8'(addr_low[ppf_pkg::EEPROM_PAGE_BYTE_BITS-1:0]); // R23
         end else begin
            page_word <= 8'(addr_low[ppf_pkg::FLASH_PAGE_WORD_BITS-1:0]); // R22
         end
      end
   end

   // busy timer for write and erase operations
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state <= PPF_IDLE;
         busy_cnt <= 16'h0000;
      end else begin
         case (state)
            PPF_IDLE: begin
               if (start_write) begin
                  state <= PPF_BUSY;
                  busy_cnt <= 16'(BUSY_CYCLES - 1);
               end
            end
            PPF_BUSY: begin
               if (busy_cnt == 16'h0000) begin
                  state <= PPF_IDLE;
               end else begin
                  busy_cnt <= busy_cnt - 16'h0001;
               end
            end
            default: state <= PPF_IDLE;
         endcase
      end
   end

   // ready flag is registered and changes on the same edge as the state
   always_ff @(posedge core_clk) begin
      if (reset) begin
         ready_busy_n <= 1'b1;
      end else begin
         ready_busy_n <= ~(start_write | (state == PPF_BUSY && busy_cnt != 16'h0000)); // R15
      end
   end

   // nonvolatile fuse cells; written bytes store 0 for programmed bits
   always_ff @(posedge core_clk) begin
      if (reset) begin
         nv_low <= ppf_pkg::LOW_DEFAULT; // R4 R5
         nv_high <= ppf_pkg::HIGH_DEFAULT; // R3
         nv_ext <= ppf_pkg::EXT_DEFAULT; // R2
      end else if (start_write && command == ppf_pkg::CMD_WRITE_FUSE && fuse_wr_ok) begin // R8
         case ({byte_select_ext, byte_select_hi_lo})
            2'h0: nv_low <= data_low; // R1
            2'h1: begin
               // serial-mode session must leave the serial enable bit alone
               if (serial_mode) begin // R6
                  nv_high <= {data_low[7:6], nv_high[ppf_pkg::HIGH_SERIAL_PROG],
                     data_low[4:0]};
               end else begin
                  nv_high <= data_low;
               end
            end
            2'h2: nv_ext <= data_low | ppf_pkg::EXT_UNUSED_MASK; // R2
            default: ;
         endcase
      end
   end
   // chip erase touches only the lock bits, never the fuse cells
   always_ff @(posedge core_clk) begin
      if (reset) begin
         lock_bits <= ppf_pkg::LOCK_DEFAULT;
         erase_pulse <= 1'b0;
      end else begin
         erase_pulse <= start_write && command == ppf_pkg::CMD_CHIP_ERASE; // R7
         if (start_write && command == ppf_pkg::CMD_CHIP_ERASE) begin
            lock_bits <= ppf_pkg::LOCK_DEFAULT;
         end else if (start_write && command == ppf_pkg::CMD_WRITE_LOCK) begin
            lock_bits <= lock_bits & data_low; // programming only clears bits
         end
      end
   end

   // working copies: taken at power-up and mode entry, refreshed at mode exit
   always_ff @(posedge core_clk) begin
      if (reset) begin
         mode_q <= 1'b0;
         init_done <= 1'b0;
         fuse_low <= ppf_pkg::LOW_DEFAULT;
         fuse_high <= ppf_pkg::HIGH_DEFAULT;
         fuse_ext <= ppf_pkg::EXT_DEFAULT;
      end else begin
         mode_q <= prog_mode;
         init_done <= 1'b1;
         if (!init_done || (prog_mode != mode_q)) begin // R9 R11
            fuse_low <= nv_low;
            fuse_high <= nv_high;
            fuse_ext <= nv_ext;
         end
      end
   end

   // keep-eeprom bypasses the delayed copy so a same-session erase honours it
   always_ff @(posedge core_clk) begin
      if (reset) begin
         keep_eeprom_on_erase <= 1'b0;
      end else begin
         keep_eeprom_on_erase <= ~nv_high[ppf_pkg::HIGH_KEEP_EEPROM]; // R10
      end
   end

   // trim byte copied into the trim register during every reset
   always_ff @(posedge core_clk) begin
      if (reset) begin
         rc_trim <= TRIM; // R13
         rc_trim_register <= 1'b1;
      end else begin
         rc_trim_register <= 1'b0;
      end
   end

   // read mux for the output-enable path
   always_comb begin
      next_data_out = 8'h00;
      case (command)
         ppf_pkg::CMD_READ_SIG: begin
            // identity bytes ignore lock state on purpose
            if (byte_select_hi_lo) begin
               next_data_out = TRIM; // R13
            end else begin
               case (addr_low)
                  8'h00: next_data_out = SIG0; // R12
                  8'h01: next_data_out = SIG1;
                  8'h02: next_data_out = SIG2;
                  default: next_data_out = 8'h00;
               endcase
            end
         end
         ppf_pkg::CMD_READ_FUSE: begin
            case ({byte_select_ext, byte_select_hi_lo})
               2'h0: next_data_out = nv_low; // R1
               2'h1: next_data_out = lock_bits;
               2'h2: next_data_out = nv_ext;
               default: next_data_out = nv_high;
            endcase
         end
         default: next_data_out = 8'h00;
      endcase
   end

   // drive the bus only under output enable; one cycle of latency
   always_ff @(posedge core_clk) begin
      if (reset) begin
         data_oe <= 1'b0;
         data_out <= 8'h00;
      end else begin
         data_oe <= prog_mode & ~output_enable_n; // R17 R20
         data_out <= next_data_out;
      end
   end

   a_oe_follow: assert property (@(posedge core_clk) disable iff (reset) // R17
      $rose(data_oe) |-> $past(!output_enable_n && prog_mode))
      else $error("bus driven without output enable");

   sequence s_write_start;
      ready_busy_n && start_write;
   endsequence
   a_busy_hold: assert property (@(posedge core_clk) disable iff (reset) // R15 R26
      s_write_start |=> !ready_busy_n)
      else $error("busy did not assert after write start");

   a_busy_ignore: assert property (@(posedge core_clk) disable iff (reset) // R27
      (state == PPF_BUSY) |=> $stable(command))
      else $error("command changed while busy");

   a_erase_fuse: assert property (@(posedge core_clk) disable iff (reset) // R7
      erase_pulse |-> $stable(nv_high) && $stable(nv_low) && $stable(nv_ext))
      else $error("chip erase changed fuses");

   a_lock_block: assert property (@(posedge core_clk) disable iff (reset) // R8
      !lock_bits[ppf_pkg::LOCK_LEVEL_BIT0] |=> $stable(nv_low))
      else $error("fuse written while locked");

   a_copy_hold: assert property (@(posedge core_clk) disable iff (reset) // R9
      (init_done && prog_mode == mode_q && $past(init_done)) |=> $stable(fuse_high))
      else $error("working fuse copy changed inside session");

   a_ext_ones: assert property (@(posedge core_clk) disable iff (reset) // R2
      (nv_ext & ppf_pkg::EXT_UNUSED_MASK) == ppf_pkg::EXT_UNUSED_MASK)
      else $error("unused extended bits not one");

   a_keep_now: assert property (@(posedge core_clk) disable iff (reset) // R10
      $fell(nv_high[ppf_pkg::HIGH_KEEP_EEPROM]) |=> keep_eeprom_on_erase)
      else $error("keep eeprom did not act at once");

   a_serial_guard: assert property (@(posedge core_clk) disable iff (reset) // R6
      serial_mode |=> $stable(nv_high[ppf_pkg::HIGH_SERIAL_PROG]))
      else $error("serial enable fuse changed in serial mode");
endmodule
`default_nettype wire

// ### dv/ppf_prog_model.sv
// programmer model: drives the parallel programming pins and its side of the data bus
`timescale 1ns/1ps
`default_nettype none
module ppf_prog_model #(
   parameter int HOLD_CYC = 1250,
   parameter int ENTRY_WAIT_CYC = 37500
) (
   input wire logic core_clk,
   input wire logic ready_busy_n,
   input wire logic [7:0] data_bus,
   output logic prog_mode,
   output logic load_strobe,
   output logic program_strobe_n,
   output logic output_enable_n,
   output logic page_latch_strobe,
   output logic pulse_action_sel1,
   output logic pulse_action_sel0,
   output logic byte_select_hi_lo,
   output logic byte_select_ext,
   output logic drv_en,
   output logic [7:0] drv_val
);
   localparam int PW = ppf_pkg::MIN_PULSE_CYC;
   logic busy_seen;
   // idle pin levels at time zero
   initial begin
      {prog_mode, load_strobe, page_latch_strobe, drv_en, busy_seen} = 5'h00;
      {program_strobe_n, output_enable_n} = 2'b11;
      {pulse_action_sel1, pulse_action_sel0, byte_select_hi_lo, byte_select_ext} = 4'h0;
      drv_val = 8'h00;
   end
   // entry pattern held low, then the settle wait before any command
   task automatic enter();
      @(negedge core_clk);
      {page_latch_strobe, pulse_action_sel1, pulse_action_sel0, byte_select_hi_lo} = 4'h0;
      prog_mode = 1'b1;
      repeat (HOLD_CYC) @(negedge core_clk);
      repeat (ENTRY_WAIT_CYC) @(negedge core_clk);
   endtask
   // bounded wait for the device to report ready
   task automatic wait_ready();
      for (int i = 0; i < 1000 && ready_busy_n !== 1'b1; i++) @(negedge core_clk);
   endtask
   // one load strobe; skipping the ready wait is how a careless programmer is mimicked
   task automatic load(input logic [1:0] act, input logic bs, input logic [7:0] val,
                       input bit wait_rdy);
      if (wait_rdy) wait_ready();
      @(negedge core_clk);
      {pulse_action_sel1, pulse_action_sel0} = act;
      byte_select_hi_lo = bs;
      drv_en = 1'b1;
      drv_val = val;
      @(negedge core_clk);
      load_strobe = 1'b1;
      repeat (PW) @(negedge core_clk);
      load_strobe = 1'b0;
      @(negedge core_clk);
      drv_en = 1'b0;
   endtask
   // write strobe; notes whether busy showed during the pulse
   task automatic wr(input logic bs, input logic ext);
      @(negedge core_clk);
      byte_select_hi_lo = bs;
      byte_select_ext = ext;
      busy_seen = 1'b0;
      @(negedge core_clk);
      program_strobe_n = 1'b0;
      repeat (PW) begin
         @(negedge core_clk);
         if (ready_busy_n === 1'b0) busy_seen = 1'b1;
      end
      program_strobe_n = 1'b1;
      @(negedge core_clk);
   endtask
   // output-enable read, sampled at a falling edge while still enabled
   task automatic rd(input logic bs, input logic ext, output logic [7:0] val);
      @(negedge core_clk);
      byte_select_hi_lo = bs;
      byte_select_ext = ext;
      output_enable_n = 1'b0;
      repeat (PW) @(negedge core_clk);
      val = data_bus;
      output_enable_n = 1'b1;
      @(negedge core_clk);
   endtask
   // page latch pulse
   task automatic page();
      @(negedge core_clk);
      page_latch_strobe = 1'b1;
      repeat (PW) @(negedge core_clk);
      page_latch_strobe = 1'b0;
      @(negedge core_clk);
   endtask
   // leave programming mode
   task automatic leave();
      @(negedge core_clk);
      prog_mode = 1'b0;
      repeat (4) @(negedge core_clk);
   endtask
endmodule
`default_nettype wire

// ### dv/testbench.sv
// self-checking testbench for the fuse store and programming front end
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam logic [7:0] SIG_A = 8'h12; // arbitrary value
   localparam logic [7:0] SIG_B = 8'h34; // arbitrary value
   localparam logic [7:0] SIG_C = 8'h56; // arbitrary value
   localparam logic [7:0] TRIM_V = 8'h4B;
   localparam logic [7:0] LOW_EXP = {1'b0, 1'b1, 2'b10, 4'b0010};
   localparam logic [7:0] HIGH_EXP = {1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 2'b00, 1'b1};
   logic core_clk, reset, serial_mode;
   logic prog_mode, load_strobe, program_strobe_n, output_enable_n, page_latch_strobe;
   logic pulse_action_sel1, pulse_action_sel0, byte_select_hi_lo, byte_select_ext, drv_en;
   logic [7:0] drv_val, data_out, fuse_low, fuse_high, fuse_ext, rc_trim, lock_bits;
   logic [7:0] addr_low, addr_high, command, page_word;
   logic data_oe, ready_busy_n, keep_eeprom_on_erase, rc_trim_register, erase_pulse;
   logic [7:0] bus_last = 8'h00;
   wire logic [7:0] data_bus;
   int num_errors = 0;
   int checks_done = 0;
   int erase_cnt = 0;
   // chip erase pulses seen; the run erases exactly once
   always @(negedge core_clk) if (erase_pulse === 1'b1) erase_cnt++;
   // a released bus shows a changing pattern instead of its last value
   assign data_bus = data_oe ? data_out : (drv_en ? drv_val : ~bus_last);
   always @(posedge core_clk) bus_last <= data_bus;
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   ppf_fuse_port #(.BUSY_CYCLES(40), .SIG0(SIG_A), .SIG1(SIG_B), .SIG2(SIG_C),
      .TRIM(TRIM_V)) i_dut (.core_clk(core_clk), .reset(reset), .prog_mode(prog_mode),
      .serial_mode(serial_mode), .load_strobe(load_strobe),
      .program_strobe_n(program_strobe_n), .output_enable_n(output_enable_n),
      .page_latch_strobe(page_latch_strobe), .pulse_action_sel1(pulse_action_sel1),
      .pulse_action_sel0(pulse_action_sel0), .byte_select_hi_lo(byte_select_hi_lo),
      .byte_select_ext(byte_select_ext), .data_in(data_bus), .data_out(data_out),
      .data_oe(data_oe), .ready_busy_n(ready_busy_n), .fuse_low(fuse_low),
      .fuse_high(fuse_high), .fuse_ext(fuse_ext),
      .keep_eeprom_on_erase(keep_eeprom_on_erase), .rc_trim_register(rc_trim_register),
      .rc_trim(rc_trim), .lock_bits(lock_bits), .addr_low(addr_low), .addr_high(addr_high),
      .command(command), .page_word(page_word), .erase_pulse(erase_pulse));
   // short entry waits keep the run brief
   ppf_prog_model #(.HOLD_CYC(50), .ENTRY_WAIT_CYC(500)) i_prog (.core_clk(core_clk),
      .ready_busy_n(ready_busy_n), .data_bus(data_bus), .prog_mode(prog_mode),
      .load_strobe(load_strobe), .program_strobe_n(program_strobe_n),
      .output_enable_n(output_enable_n), .page_latch_strobe(page_latch_strobe),
      .pulse_action_sel1(pulse_action_sel1), .pulse_action_sel0(pulse_action_sel0),
      .byte_select_hi_lo(byte_select_hi_lo), .byte_select_ext(byte_select_ext),
      .drv_en(drv_en), .drv_val(drv_val));
   // compare and count
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // reset values of the working fuse copies and outputs
   task automatic t_defaults();
      check("fuse_ext", fuse_ext, 8'hFF);
      check("fuse_high", fuse_high, HIGH_EXP);
      check("fuse_low", fuse_low, LOW_EXP);
      check("startup_sel", {6'h00, fuse_low[5:4]}, 8'h02);
      check("lock_bits", lock_bits, 8'hFF);
      check("keep_eeprom", {7'h00, keep_eeprom_on_erase}, 8'h00);
      check("ready", {7'h00, ready_busy_n}, 8'h01);
      check("bus_enable", {7'h00, data_oe}, 8'h00);
      check("rc_trim", rc_trim, TRIM_V);
   endtask
   // identity bytes and trim byte through the signature command
   task automatic t_signature();
      logic [7:0] v;
      logic [7:0] sig [3];
      sig = '{SIG_A, SIG_B, SIG_C};
      i_prog.load(2'b10, 1'b0, 8'h08, 1);
      for (int i = 0; i < 3; i++) begin
         i_prog.load(2'b00, 1'b0, 8'(i), 1);
         i_prog.rd(1'b0, 1'b0, v);
         check("signature", v, sig[i]);
      end
      i_prog.load(2'b00, 1'b0, 8'h00, 1);
      i_prog.rd(1'b1, 1'b0, v);
      check("trim_byte", v, TRIM_V);
   endtask
   // all four fuse/lock read selections
   task automatic t_read_fuses();
      logic [7:0] v;
      logic [7:0] exp [4];
      exp = '{LOW_EXP, 8'hFF, 8'hFF, HIGH_EXP};
      i_prog.load(2'b10, 1'b0, 8'h04, 1);
      for (int i = 0; i < 4; i++) begin
         i_prog.rd(i[0], i[1], v);
         check("fuse_read", v, exp[i]);
         check("bus_released", {7'h00, data_oe}, 8'h00);
      end
   endtask
   // high fuse write from a serial session: keep-eeprom acts now, the rest waits
   task automatic t_write_high();
      serial_mode = 1'b1;
      i_prog.load(2'b10, 1'b0, 8'h40, 1);
      i_prog.load(2'b01, 1'b0, 8'hB1, 1);
      i_prog.wr(1'b1, 1'b0);
      check("busy_seen", {7'h00, i_prog.busy_seen}, 8'h01);
      i_prog.wait_ready();
      check("keep_eeprom", {7'h00, keep_eeprom_on_erase}, 8'h01);
      check("fuse_high_held", fuse_high, HIGH_EXP);
      serial_mode = 1'b0;
   endtask
   // chip erase, then a command load that arrives while still busy
   task automatic t_erase();
      i_prog.load(2'b10, 1'b0, 8'h80, 1);
      i_prog.wr(1'b0, 1'b0);
      check("busy_seen", {7'h00, i_prog.busy_seen}, 8'h01);
      check("erase_pulse", 8'(erase_cnt), 8'h01);
      i_prog.load(2'b10, 1'b0, 8'h08, 0);
      check("cmd_while_busy", command, 8'h80);
      i_prog.wait_ready();
      check("fuse_low", fuse_low, LOW_EXP);
      check("fuse_high", fuse_high, HIGH_EXP);
   endtask
   // mode exit takes the new fuses; a later reset restores defaults and the trim
   task automatic t_exit_reset();
      logic seen;
      i_prog.leave();
      check("keep_bit", {7'h00, fuse_high[3]}, 8'h00);
      check("serial_bit", {7'h00, fuse_high[5]}, 8'h00);
      @(negedge core_clk);
      reset = 1'b1;
      seen = 1'b0;
      repeat (3) @(negedge core_clk) if (rc_trim_register === 1'b1) seen = 1'b1;
      reset = 1'b0;
      repeat (3) @(negedge core_clk);
      check("trim_load", {7'h00, seen}, 8'h01);
      check("rc_trim", rc_trim, TRIM_V);
      check("powerup_keep", {7'h00, fuse_high[3]}, 8'h01);
   endtask
   // address/command loads, idle code, word and byte in page, and retention over an operation
   task automatic t_addr_page();
      i_prog.enter();
      i_prog.load(2'b10, 1'b0, 8'h10, 1);
      i_prog.load(2'b00, 1'b0, 8'hC5, 1);
      i_prog.load(2'b00, 1'b1, 8'h3A, 1);
      i_prog.load(2'b11, 1'b0, 8'h77, 1);
      check("addr_low", addr_low, 8'hC5);
      check("addr_high", addr_high, 8'h3A);
      check("command", command, 8'h10);
      i_prog.load(2'b01, 1'b0, 8'h11, 1);
      i_prog.page();
      check("flash_word", page_word, 8'h05);
      i_prog.load(2'b10, 1'b0, 8'h11, 1);
      i_prog.load(2'b00, 1'b0, 8'hC6, 1);
      i_prog.load(2'b01, 1'b0, 8'h22, 1);
      i_prog.page();
      check("eeprom_byte", page_word, 8'h02);
      i_prog.wr(1'b0, 1'b0);
      i_prog.wait_ready();
      check("addr_kept", addr_low, 8'hC6);
      check("cmd_kept", command, 8'h11);
   endtask
   // lock bit0 blocks fuse writes; identity still readable while locked
   task automatic t_lock();
      logic [7:0] v;
      i_prog.load(2'b10, 1'b0, 8'h20, 1);
      i_prog.load(2'b01, 1'b0, 8'hFE, 1);
      i_prog.wr(1'b0, 1'b0);
      i_prog.load(2'b10, 1'b0, 8'h40, 1);
      i_prog.load(2'b01, 1'b0, 8'h00, 1);
      i_prog.wr(1'b0, 1'b0);
      i_prog.load(2'b10, 1'b0, 8'h08, 1);
      i_prog.load(2'b00, 1'b0, 8'h01, 1);
      i_prog.rd(1'b0, 1'b0, v);
      check("locked_sig", v, SIG_B);
      i_prog.leave();
      check("lock_bit0", {7'h00, lock_bits[0]}, 8'h00);
      check("fuse_low_kept", fuse_low, LOW_EXP);
   endtask
   // main sequence
   initial begin
      reset = 1'b1;
      serial_mode = 1'b0;
      repeat (8) @(negedge core_clk);
      reset = 1'b0;
      repeat (3) @(negedge core_clk);
      t_defaults();
      i_prog.enter();
      t_signature();
      t_read_fuses();
      t_write_high();
      t_erase();
      t_exit_reset();
      t_addr_page();
      t_lock();
      wrap_up();
   end
   // watchdog, well beyond the few thousand cycles the sequence needs
   initial begin
      repeat (60000) @(posedge core_clk);
      num_errors++;
      wrap_up();
   end
endmodule
`default_nettype wire
